// File: rtl/ilm_core.sv
// Executor for indirect loads, literal loads and the accumulator store
//
// Chosen here: the register offsets and the APB slave port.
`default_nettype none
module ilm_core
   import ilm_pkg::*;
(
   input  wire logic        mclk,
   input  wire logic        rst_b,
   input  wire ilm_instr_t  instr,
   output logic             instr_ready,
   output ilm_dreq_t        dreq,
   input  wire logic        drsp_valid,
   input  wire logic [7:0]  drsp_data,
   output ilm_fwr_t         fwr,
   output logic [15:0]      ptr0,
   output logic [15:0]      ptr1,
   output logic [7:0]       acc,
   output logic [4:0]       bank,
   output logic [6:0]       page,
   output logic             zero,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr
);
   ilm_state_t s_q;
   ilm_state_t s_d;

   ////////////////////////////////////////////////////////////////////////////
   function automatic logic [15:0] step(input logic [15:0] p, input logic dec);
      step = dec ? p - ILM_PTR_ONE : p + ILM_PTR_ONE;
   endfunction

   function automatic logic [15:0] sext_ofs(input logic [5:0] k);
      sext_ofs = {{10{k[5]}}, k};
   endfunction

   function automatic logic mapped(input logic [11:0] a);
      mapped = (a == ILM_PTR0_OFS) || (a == ILM_PTR1_OFS) || (a == ILM_ACC_OFS) ||
               (a == ILM_BANK_OFS) || (a == ILM_PAGE_OFS) || (a == ILM_STAT_OFS) ||
               (a == ILM_CNT_OFS);
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   logic        busy;
   logic [15:0] cur;
   logic        apb_acc;

   assign busy        = s_q.dreq.req;
   assign cur         = s_q.ptr[instr.sel];
   assign instr_ready = !busy;
   assign apb_acc     = psel && penable && !s_q.pready;

   always_comb
   begin
      s_d        = s_q;
      s_d.fwr.we = 1'b0;
      s_d.pready = 1'b0;
      if (busy)
      begin
         if (drsp_valid)
         begin
            s_d.dreq.req = 1'b0;
            s_d.acc      = drsp_data;
            s_d.zero     = drsp_data == 8'h00;
            s_d.cnt      = s_q.cnt + 16'h0001;
         end
      end
      else if (instr.valid)
      begin
         case (instr.op)
            ILM_OP_LDIND:
            begin
               s_d.dreq.req = 1'b1;
               case (instr.upd)
                  ILM_MM_PREINC, ILM_MM_PREDEC:
                  begin
                     s_d.dreq.addr         = step(cur, instr.upd[0]);
                     s_d.ptr[instr.sel]    = step(cur, instr.upd[0]);
                  end
                  default:
                  begin
                     s_d.dreq.addr         = cur;
                     s_d.ptr[instr.sel]    = step(cur, instr.upd[0]);
                  end
               endcase
            end
            ILM_OP_LDREL:
            begin
               s_d.dreq.req  = 1'b1;
               s_d.dreq.addr = cur + sext_ofs(instr.imm[5:0]);
            end
            ILM_OP_LBANK: s_d.bank = instr.imm[4:0];
            ILM_OP_LPAGE: s_d.page = instr.imm[6:0];
            ILM_OP_LACC:  s_d.acc  = instr.imm;
            ILM_OP_STACC:
            begin
               s_d.fwr.we   = 1'b1;
               s_d.fwr.addr = instr.imm[6:0];
               s_d.fwr.data = s_q.acc;
            end
            default: s_d.cnt = s_q.cnt;
         endcase
      end
      // APB slave: one wait state, software writes only while core idle
      if (apb_acc)
      begin
         s_d.pready = 1'b1;
         s_d.prdata = 32'h0000_0000;
         case (paddr)
            ILM_PTR0_OFS: s_d.prdata = {16'h0000, s_q.ptr[0]};
            ILM_PTR1_OFS: s_d.prdata = {16'h0000, s_q.ptr[1]};
            ILM_ACC_OFS:  s_d.prdata = {24'h00_0000, s_q.acc};
            ILM_BANK_OFS: s_d.prdata = {27'h000_0000, s_q.bank};
            ILM_PAGE_OFS: s_d.prdata = {25'h000_0000, s_q.page};
            ILM_STAT_OFS: s_d.prdata = {30'h0000_0000, busy, s_q.zero};
            ILM_CNT_OFS:  s_d.prdata = {16'h0000, s_q.cnt};
            default:      s_d.prdata = 32'h0000_0000;
         endcase
      end
      // Write lands at the edge that completes the transfer
      if (psel && penable && s_q.pready && pwrite && !busy && !instr.valid)
      begin
         case (paddr)
            ILM_PTR0_OFS: s_d.ptr[0] = pwdata[15:0];
            ILM_PTR1_OFS: s_d.ptr[1] = pwdata[15:0];
            ILM_CNT_OFS:  s_d.cnt    = 16'h0000;
            default:      s_d.cnt    = s_d.cnt;
         endcase
      end
   end

   always_ff @(posedge mclk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         s_q        <= '0;
         s_q.ptr[0] <= ILM_PTR_RST;
         s_q.ptr[1] <= ILM_PTR_RST;
         s_q.acc    <= ILM_ACC_RST;
         s_q.bank   <= ILM_BANK_RST;
         s_q.page   <= ILM_PAGE_RST;
      end
      else
      begin
         s_q <= s_d;
      end
   end

   assign dreq    = s_q.dreq;
   assign fwr     = s_q.fwr;
   assign ptr0    = s_q.ptr[0];
   assign ptr1    = s_q.ptr[1];
   assign acc     = s_q.acc;
   assign bank    = s_q.bank;
   assign page    = s_q.page;
   assign zero    = s_q.zero;
   assign prdata  = s_q.prdata;
   assign pready  = s_q.pready;
   assign pslverr = s_q.pready && !mapped(paddr);

   ////////////////////////////////////////////////////////////////////////////
   logic take;
   logic go_lacc;
   logic go_ind;
   assign take    = instr.valid && !busy;
   assign go_lacc = take && instr.op == ILM_OP_LACC;
   assign go_ind  = take && instr.op == ILM_OP_LDIND;

   literal_acc_a: assert property (@(posedge mclk) disable iff (!rst_b)
      go_lacc |=> acc == $past(instr.imm) && $stable(zero))
      else $error("accumulator literal not loaded");
   literal_bank_a: assert property (@(posedge mclk) disable iff (!rst_b)
      take && instr.op == ILM_OP_LBANK |=> bank == $past(instr.imm[4:0]) && $stable(zero))
      else $error("bank literal not loaded");
   literal_page_a: assert property (@(posedge mclk) disable iff (!rst_b)
      take && instr.op == ILM_OP_LPAGE |=> page == $past(instr.imm[6:0]) && $stable(zero))
      else $error("page literal not loaded");
   store_file_a: assert property (@(posedge mclk) disable iff (!rst_b)
      take && instr.op == ILM_OP_STACC |=> fwr.we && fwr.data == $past(acc)
      && fwr.addr == $past(instr.imm[6:0]) && $stable(zero))
      else $error("store did not write file register");
   pre_inc_a: assert property (@(posedge mclk) disable iff (!rst_b)
      go_ind && instr.upd == ILM_MM_PREINC && !instr.sel
      |=> dreq.req && dreq.addr == $past(ptr0) + 16'h0001 && ptr0 == dreq.addr)
      else $error("pre-increment address wrong");
   pre_dec_a: assert property (@(posedge mclk) disable iff (!rst_b)
      go_ind && instr.upd == ILM_MM_PREDEC && instr.sel
      |=> dreq.req && dreq.addr == $past(ptr1) - 16'h0001 && ptr1 == dreq.addr)
      else $error("pre-decrement address wrong");
   post_inc_a: assert property (@(posedge mclk) disable iff (!rst_b)
      go_ind && instr.upd == ILM_MM_POSTINC && !instr.sel
      |=> dreq.addr == $past(ptr0) && ptr0 == $past(ptr0) + 16'h0001)
      else $error("post-increment wrong");
   post_dec_a: assert property (@(posedge mclk) disable iff (!rst_b)
      go_ind && instr.upd == ILM_MM_POSTDEC && instr.sel
      |=> dreq.addr == $past(ptr1) && ptr1 == $past(ptr1) - 16'h0001)
      else $error("post-decrement wrong");
   rel_keep_a: assert property (@(posedge mclk) disable iff (!rst_b)
      take && instr.op == ILM_OP_LDREL |=> dreq.req && $stable(ptr0) && $stable(ptr1))
      else $error("offset mode changed pointer");
   req_hold_a: assert property (@(posedge mclk) disable iff (!rst_b)
      busy && !drsp_valid |=> dreq.req && $stable(dreq.addr) && $stable(acc))
      else $error("pending indirect request dropped");
   zero_flag_a: assert property (@(posedge mclk) disable iff (!rst_b)
      busy && drsp_valid |=> !dreq.req && acc == $past(drsp_data) && zero == ($past(drsp_data) == 8'h00))
      else $error("indirect load result or zero flag wrong");
   store_cov_c: cover property (@(posedge mclk) disable iff (!rst_b) fwr.we);
   lacc_cov_c: cover property (@(posedge mclk) disable iff (!rst_b) go_lacc);
   ind_cov_c: cover property (@(posedge mclk) disable iff (!rst_b) busy && drsp_valid && drsp_data == 8'h00);
   wrap_cov_c: cover property (@(posedge mclk) disable iff (!rst_b) $past(ptr0) == 16'hFFFF && ptr0 == 16'h0000);
endmodule
`default_nettype wire

// File: rtl/ilm_pkg.sv
// Package: constants and types for the indirect and literal move executor
`default_nettype none
package ilm_pkg;
   localparam int ILM_PTR_W = 16;
   localparam int ILM_OFS_W = 6;
   localparam int ILM_BANK_W = 5;
   localparam int ILM_PAGE_W = 7;
   localparam int ILM_FILE_W = 7;
   localparam logic [15:0] ILM_PTR_RST = 16'h0000;
   localparam logic [7:0] ILM_ACC_RST = 8'h00;
   localparam logic [4:0] ILM_BANK_RST = 5'h00;
   localparam logic [6:0] ILM_PAGE_RST = 7'h00;
   localparam logic [15:0] ILM_PTR_ONE = 16'h0001;

   // APB register byte offsets
   localparam logic [11:0] ILM_PTR0_OFS = 12'h000;
   localparam logic [11:0] ILM_PTR1_OFS = 12'h004;
   localparam logic [11:0] ILM_ACC_OFS = 12'h008;
   localparam logic [11:0] ILM_BANK_OFS = 12'h00C;
   localparam logic [11:0] ILM_PAGE_OFS = 12'h010;
   localparam logic [11:0] ILM_STAT_OFS = 12'h014;
   localparam logic [11:0] ILM_CNT_OFS = 12'h018;

   // Instruction opcodes on the decoded instruction port
   typedef enum logic [2:0]
   {
      ILM_OP_NOP   = 3'b000,
      ILM_OP_LDIND = 3'b001,
      ILM_OP_LDREL = 3'b010,
      ILM_OP_LBANK = 3'b011,
      ILM_OP_LPAGE = 3'b100,
      ILM_OP_LACC  = 3'b101,
      ILM_OP_STACC = 3'b110
   } ilm_op_t;

   typedef enum logic [1:0]
   {
      ILM_MM_PREINC  = 2'b00,
      ILM_MM_PREDEC  = 2'b01,
      ILM_MM_POSTINC = 2'b10,
      ILM_MM_POSTDEC = 2'b11
   } ilm_upd_t;

   typedef struct packed {
      logic     valid;
      ilm_op_t  op;
      logic     sel;
      ilm_upd_t upd;
      logic [7:0] imm;
   } ilm_instr_t;

   typedef struct packed {
      logic        req;
      logic [15:0] addr;
   } ilm_dreq_t;

   typedef struct packed {
      logic       we;
      logic [6:0] addr;
      logic [7:0] data;
   } ilm_fwr_t;

   typedef struct packed {
      logic [1:0][15:0] ptr;
      logic [7:0]       acc;
      logic [4:0]       bank;
      logic [6:0]       page;
      logic             zero;
      logic [15:0]      cnt;
      ilm_dreq_t        dreq;
      ilm_fwr_t         fwr;
      logic [31:0]      prdata;
      logic             pready;
   } ilm_state_t;
endpackage
`default_nettype wire

// File: dv/ilm_tb.sv
// Directed testbench for the indirect and literal move executor
`default_nettype none
module testbench
   import ilm_pkg::*;
();
   timeunit 1ns;
   timeprecision 1ps;
   logic        mclk, rst_b, instr_ready, drsp_valid, psel, penable, pwrite, pready, pslverr, zero, err;
   ilm_instr_t  instr;
   ilm_dreq_t   dreq;
   ilm_fwr_t    fwr;
   logic [15:0] ptr0, ptr1;
   logic [7:0]  acc, drsp_data;
   logic [4:0]  bank;
   logic [6:0]  page;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   int          miscompares, cmp_count;

   ilm_core DUT (.mclk, .rst_b, .instr, .instr_ready, .dreq, .drsp_valid, .drsp_data, .fwr, .ptr0, .ptr1,
      .acc, .bank, .page, .zero, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr);

   ////////////////////////////////////////////////////////////////////////////////
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic summarize();
      $display("Counts: %0d mismatches, %0d comparisons", miscompares, cmp_count);
      if (miscompares == 0 && cmp_count > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   // One APB transfer, held until pready is sampled high
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge mclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      do
      begin
         @(posedge mclk);
         n++;
      end
      while (pready !== 1'b1 && n < 20);
      if (n >= 20)
         miscompares++;
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic lit(input ilm_op_t op, input logic [7:0] k);
      @(posedge mclk);
      instr <= '{1'b1, op, 1'b0, ILM_MM_PREINC, k};
      @(posedge mclk);
      instr.valid <= 1'b0;
      #1;
      check(32'(instr_ready), 32'h0000_0001);
   endtask

   // Indirect load: expect address ea, answer with byte d
   task automatic ind(input ilm_op_t op, input logic s, input ilm_upd_t u, input logic [7:0] k,
                      input logic [7:0] d, input logic [15:0] ea);
      int n;
      n = 0;
      @(posedge mclk);
      instr <= '{1'b1, op, s, u, k};
      @(posedge mclk);
      instr.valid <= 1'b0;
      #1;
      while (dreq.req !== 1'b1 && n < 20)
      begin
         @(posedge mclk);
         #1;
         n++;
      end
      check(32'({instr_ready, dreq}), {14'h0000, 2'h1, ea});
      @(posedge mclk);
      drsp_valid <= 1'b1;
      drsp_data <= d;
      @(posedge mclk);
      drsp_valid <= 1'b0;
      drsp_data <= ~d;
      repeat (2) @(posedge mclk);
      #1;
      check(32'(acc), 32'(d));
      check(32'(zero), 32'(d == 8'h00));
      check(32'({instr_ready, dreq.req}), 32'h0000_0002);
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   initial
   begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end

   initial
   begin
      #20000;
      miscompares++;
      summarize();
   end

   initial
   begin
      rst_b = 1'b0;
      instr = '0;
      drsp_valid = 1'b0;
      drsp_data = 8'h00;
      {psel, penable, pwrite, paddr, pwdata} = '0;
      miscompares = 0;
      cmp_count = 0;
      repeat (3) @(posedge mclk);
      rst_b <= 1'b1;
      apb(1'b0, ILM_PTR1_OFS, 32'h0000_0000);
      check(rd, 32'h0000_0000);
      apb(1'b1, ILM_PTR0_OFS, 32'h0000_FFFF);
      ind(ILM_OP_LDIND, 1'b0, ILM_MM_PREINC, 8'h00, 8'h00, 16'h0000);
      check(32'(ptr0), 32'h0000_0000);
      ind(ILM_OP_LDIND, 1'b1, ILM_MM_PREDEC, 8'h00, 8'h5A, 16'hFFFF);
      check({ptr1, ptr0}, 32'hFFFF_0000);
      ind(ILM_OP_LDIND, 1'b0, ILM_MM_POSTINC, 8'h00, 8'h00, 16'h0000);
      check(32'(ptr0), 32'h0000_0001);
      ind(ILM_OP_LDIND, 1'b1, ILM_MM_POSTDEC, 8'h00, 8'hC3, 16'hFFFF);
      check(32'(ptr1), 32'h0000_FFFE);
      ind(ILM_OP_LDREL, 1'b0, ILM_MM_PREINC, 8'h20, 8'h00, 16'hFFE1);
      check(32'(ptr0), 32'h0000_0001);
      ind(ILM_OP_LDREL, 1'b1, ILM_MM_PREINC, 8'h1F, 8'h81, 16'h001D);
      check(32'(ptr1), 32'h0000_FFFE);
      lit(ILM_OP_LACC, 8'h00);
      check(32'({acc, 7'h00, zero}), 32'h0000_0000);
      lit(ILM_OP_LACC, 8'hFF);
      check(32'(acc), 32'h0000_00FF);
      lit(ILM_OP_STACC, 8'h7F);
      check(32'(fwr), 32'h0000_FFFF);
      ind(ILM_OP_LDIND, 1'b0, ILM_MM_PREINC, 8'h00, 8'h00, 16'h0002);
      lit(ILM_OP_LBANK, 8'h1F);
      check(32'({bank, zero}), 32'h0000_003F);
      lit(ILM_OP_LPAGE, 8'h7F);
      check(32'({page, zero}), 32'h0000_00FF);
      lit(ILM_OP_NOP, 8'h55);
      check(32'({acc, bank, page, zero}), 32'h0000_1FFF);
      apb(1'b0, 12'h0FC, 32'h0000_0000);
      check(rd, 32'h0000_0000);
      check(32'(err), 32'h0000_0001);
      apb(1'b0, ILM_BANK_OFS, 32'h0000_0000);
      check(rd, 32'h0000_001F);
      check(32'(err), 32'h0000_0000);
      apb(1'b0, ILM_PAGE_OFS, 32'h0000_0000);
      check(rd, 32'h0000_007F);
      apb(1'b0, ILM_STAT_OFS, 32'h0000_0000);
      check(rd, 32'h0000_0001);
      apb(1'b0, ILM_CNT_OFS, 32'h0000_0000);
      check(rd, 32'h0000_0007);
      apb(1'b0, ILM_PTR0_OFS, 32'h0000_0000);
      check(rd, 32'h0000_0002);
      summarize();
   end
endmodule
`default_nettype wire
